// file: design/lane_fifo_alarm_and_offset_trim_regs.sv
// Lane elastic buffer alarm flags and per-core offset trim registers behind an AXI4-Lite slave.
//
// Local design decision: the AXI4-Lite slave port.
`default_nettype none

// How it works
// [R1] Lane buffer fault sets its lane flag.
// [R2] Writing one clears a lane flag.
// [R3] Persisting fault sets flag again immediately.
// [R4] Summary write-one clears all lane flags.
// [R5] Lane flags read all ones after reset.
// [R6] Trim holds unsigned 12-bit offset per core.
// [R7] Software writes zero into bits 15:12.
// [R8] Software avoids trims during offset calibration.
// [R9] Foreground-only offset cal: wait for done.
// [R10] Background offset tracking: never touch trims.
// [R11] Prefer background cal without offset tracking.
// [R12] Otherwise trims are free to access.
// [R13] Second trim drives core 1 offset.
// [R14] Third trim applies only on input A.
// [R15] Working trim default loads from fuses.
// [R16] Summary alarm sets on active lane fault.
// [R17] Alarm bits read one after reset.
// [R18] Trim applies only after both bytes written.
module lane_fifo_alarm_and_offset_trim_regs #(
	parameter int LANES = 8
) (
	input wire logic clk, // System clock, 25 MHz.
	input wire logic rst, // Synchronous reset, active high.
	input wire logic ce, // Clock enable; all state holds while low.
	input wire trim_regs_pkg::axil_req_t axi_req, // AXI4-Lite master to slave.
	output trim_regs_pkg::axil_rsp_t axi_rsp, // AXI4-Lite slave to master.
	input wire logic [LANES-1:0] lane_overflow, // Per-lane elastic buffer overflow.
	input wire logic [LANES-1:0] lane_underflow, // Per-lane elastic buffer underflow.
	input wire logic [LANES-1:0] lane_active, // Lanes counted in the summary.
	input wire logic fuse_load, // Pulse: take factory trims.
	input wire logic [trim_regs_pkg::NUM_CORES-1:0][trim_regs_pkg::TRIM_W-1:0] fuse_trim, // Factory trims.
	input wire logic offset_cal_busy, // Calibration engine is running offset cal.
	input wire logic foreground_cal_done, // Foreground calibration finished.
	input wire logic core2_samples_a, // Core 2 currently samples input A.
	output logic [trim_regs_pkg::TRIM_W-1:0] core0_offset, // Applied core 0 offset.
	output logic [trim_regs_pkg::TRIM_W-1:0] core1_offset, // Applied core 1 offset.
	output logic [trim_regs_pkg::TRIM_W-1:0] core2_input_a_offset, // Core 2 offset, zero off input A.
	output logic core2_input_a_offset_active, // Core 2 input A offset in use.
	output logic offset_cal_enable, // Offset calibration enable.
	output logic background_cal_enable, // Background calibration enable.
	output logic background_offset_tracking_enable // Background offset tracking enable.
);
	import trim_regs_pkg::*;

	// Refuses a lane count that the eight-bit flag register cannot hold.
	if (LANES < 1 || LANES > MAX_LANES) begin : g_lanes_bad
		$error("LANES must lie between 1 and 8.");
	end

	bank_state_t st_ff;
	bank_state_t nxt_st;

	logic [7:0] lane_mask;
	logic [7:0] lane_fault;
	logic [7:0] lane_live;

	always_comb begin
		lane_mask = '0;
		lane_mask[LANES-1:0] = '1;
		lane_fault = '0;
		lane_fault[LANES-1:0] = lane_overflow | lane_underflow;
		lane_live = '0;
		lane_live[LANES-1:0] = lane_active;
	end

	// ----------------------------------------------------------------
	// Register read mux
	// ----------------------------------------------------------------
	function automatic logic [31:0] read_word(input logic [11:0] idx, input bank_state_t s,
		input logic busy, input logic done);
		logic [31:0] w;
		w = '0;
		case (idx)
			IDX_ALARM_STATUS: w[SUMMARY_BIT] = s.summary;
			IDX_LANE_FLAGS: w[7:0] = s.lane_flags;
			IDX_CORE0_TRIM: w[15:0] = s.trim_shadow[0];
			IDX_CORE1_TRIM: w[15:0] = s.trim_shadow[1];
			IDX_CORE2A_TRIM: w[15:0] = s.trim_shadow[2];
			IDX_CAL_CTRL: w[2:0] = s.cal_ctrl;
			IDX_CAL_STATUS: begin
				w[STAT_FOREGROUND_CAL_DONE_BIT] = done;
				w[STAT_BUSY_BIT] = busy;
				w[STAT_VIOL_BIT] = s.violation;
			end
			default: w = '0;
		endcase
		return w;
	endfunction

	function automatic logic is_mapped(input logic [11:0] idx);
		logic m;
		m = 1'b0;
		case (idx)
			IDX_ALARM_STATUS, IDX_LANE_FLAGS, IDX_CORE0_TRIM, IDX_CORE1_TRIM,
			IDX_CORE2A_TRIM, IDX_CAL_CTRL, IDX_CAL_STATUS: m = 1'b1;
			default: m = 1'b0;
		endcase
		return m;
	endfunction

	function automatic int trim_slot(input logic [11:0] idx);
		int k;
		k = -1;
		case (idx)
			IDX_CORE0_TRIM: k = 0;
			IDX_CORE1_TRIM: k = 1;
			IDX_CORE2A_TRIM: k = 2;
			default: k = -1;
		endcase
		return k;
	endfunction

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	logic [11:0] wr_idx;
	logic [11:0] rd_idx;
	logic do_write;
	logic do_read;
	logic restricted;
	logic trim_touch;
	int wr_slot;

	always_comb begin
		nxt_st = st_ff;
		wr_idx = st_ff.awaddr[ADDR_W-1:2];
		rd_idx = axi_req.araddr[ADDR_W-1:2];
		do_write = st_ff.aw_held && st_ff.w_held && !st_ff.bvalid;
		do_read = axi_req.arvalid && !st_ff.rvalid;
		wr_slot = trim_slot(wr_idx);
		restricted = 1'b0;
		trim_touch = 1'b0;

		// Write channels are taken independently and held until the response.
		if (axi_req.awvalid && !st_ff.aw_held && !st_ff.bvalid) begin
			nxt_st.aw_held = 1'b1;
			nxt_st.awaddr = axi_req.awaddr;
		end
		if (axi_req.wvalid && !st_ff.w_held && !st_ff.bvalid) begin
			nxt_st.w_held = 1'b1;
			nxt_st.wdata = axi_req.wdata;
			nxt_st.wstrb = axi_req.wstrb;
		end
		if (st_ff.bvalid && axi_req.bready) begin
			nxt_st.bvalid = 1'b0;
		end
		if (st_ff.rvalid && axi_req.rready) begin
			nxt_st.rvalid = 1'b0;
		end

		// Factory trims replace the working values; the printed zero is only the reset value.
		if (fuse_load) begin
			for (int c = 0; c < NUM_CORES; c++) begin
				nxt_st.trim_shadow[c] = {4'h0, fuse_trim[c]}; // R15
				nxt_st.trim_apply[c] = fuse_trim[c]; // R15
				nxt_st.trim_seen[c] = 2'h0;
			end
		end

		if (do_write) begin
			nxt_st.aw_held = 1'b0;
			nxt_st.w_held = 1'b0;
			nxt_st.bvalid = 1'b1;
			nxt_st.bresp = is_mapped(wr_idx) ? RESP_OKAY : RESP_DECERR;
			case (wr_idx)
				IDX_LANE_FLAGS: begin
					if (st_ff.wstrb[0]) begin
						nxt_st.lane_flags = st_ff.lane_flags & ~st_ff.wdata[7:0]; // R2
					end
				end
				IDX_ALARM_STATUS: begin
					if (st_ff.wstrb[0] && st_ff.wdata[SUMMARY_BIT]) begin
						nxt_st.summary = 1'b0; // R4
						nxt_st.lane_flags = '0; // R4
					end
				end
				IDX_CAL_CTRL: begin
					if (st_ff.wstrb[0]) begin
						nxt_st.cal_ctrl = st_ff.wdata[2:0];
					end
				end
				IDX_CAL_STATUS: begin
					if (st_ff.wstrb[0] && st_ff.wdata[STAT_VIOL_BIT]) begin
						nxt_st.violation = 1'b0;
					end
				end
				default: begin
					if (wr_slot >= 0) begin
						// Byte lanes are collected; the pair is applied once both have arrived.
						for (int b = 0; b < 2; b++) begin
							if (st_ff.wstrb[b]) begin
								nxt_st.trim_shadow[wr_slot][b*8 +: 8] = st_ff.wdata[b*8 +: 8]; // R6
								nxt_st.trim_seen[wr_slot][b] = 1'b1; // R18
							end
						end
						if (nxt_st.trim_seen[wr_slot] == 2'h3) begin
							nxt_st.trim_apply[wr_slot] = nxt_st.trim_shadow[wr_slot][TRIM_W-1:0]; // R18
							nxt_st.trim_seen[wr_slot] = 2'h0; // R18
						end
					end
				end
			endcase
		end

		if (do_read) begin
			nxt_st.rvalid = 1'b1;
			nxt_st.rdata = read_word(rd_idx, st_ff, offset_cal_busy, foreground_cal_done);
			nxt_st.rresp = is_mapped(rd_idx) ? RESP_OKAY : RESP_DECERR;
		end

		// Access to the trims in a restricted calibration phase is recorded, not blocked.
		restricted = offset_cal_busy; // R8
		if (st_ff.cal_ctrl[OFFSET_CAL_ENABLE_BIT] && (!st_ff.cal_ctrl[BACKGROUND_CAL_ENABLE_BIT] || !st_ff.cal_ctrl[BACKGROUND_OFFSET_TRACKING_ENABLE_BIT])
			&& !foreground_cal_done) begin
			restricted = 1'b1; // R9 R11
		end
		if (st_ff.cal_ctrl[BACKGROUND_CAL_ENABLE_BIT] && st_ff.cal_ctrl[BACKGROUND_OFFSET_TRACKING_ENABLE_BIT]) begin
			restricted = 1'b1; // R10
		end
		trim_touch = (do_write && wr_slot >= 0) || (do_read && trim_slot(rd_idx) >= 0);
		if (restricted && trim_touch) begin
			nxt_st.violation = 1'b1; // R12
		end

		// Faults are applied after the clears so that a fault in the clearing cycle survives.
		nxt_st.lane_flags = (nxt_st.lane_flags | lane_fault) & lane_mask; // R1 R3
		if ((lane_fault & lane_live) != 8'h00) begin
			nxt_st.summary = 1'b1; // R16
		end

		nxt_st.core2_active = core2_samples_a; // R14
		nxt_st.core2_out = core2_samples_a ? nxt_st.trim_apply[2] : '0; // R14
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			st_ff <= '0;
			st_ff.lane_flags <= LANE_FLAGS_RST & lane_mask; // R5 R17
			st_ff.summary <= SUMMARY_RST; // R17
			st_ff.trim_shadow <= {NUM_CORES{TRIM_RST}};
			st_ff.cal_ctrl <= CAL_CTRL_RST;
		end else if (ce) begin
			st_ff <= nxt_st;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	always_comb begin
		// Readies follow the clock enable, so no request is taken while the state is frozen.
		axi_rsp.awready = ce && !st_ff.aw_held && !st_ff.bvalid;
		axi_rsp.wready = ce && !st_ff.w_held && !st_ff.bvalid;
		axi_rsp.bvalid = st_ff.bvalid;
		axi_rsp.bresp = st_ff.bresp;
		axi_rsp.arready = ce && !st_ff.rvalid;
		axi_rsp.rvalid = st_ff.rvalid;
		axi_rsp.rdata = st_ff.rdata;
		axi_rsp.rresp = st_ff.rresp;
	end

	assign core0_offset = st_ff.trim_apply[0]; // R6
	assign core1_offset = st_ff.trim_apply[1]; // R13
	assign core2_input_a_offset = st_ff.core2_out;
	assign core2_input_a_offset_active = st_ff.core2_active;
	assign offset_cal_enable = st_ff.cal_ctrl[OFFSET_CAL_ENABLE_BIT];
	assign background_cal_enable = st_ff.cal_ctrl[BACKGROUND_CAL_ENABLE_BIT];
	assign background_offset_tracking_enable = st_ff.cal_ctrl[BACKGROUND_OFFSET_TRACKING_ENABLE_BIT];

endmodule

`default_nettype wire

// file: design/trim_regs_pkg.sv
// Package with the register map, field layout, bus carriers and state of the lane alarm and offset trim bank.
`default_nettype none

package trim_regs_pkg;

	// ----------------------------------------------------------------
	// Register indices; byte address is four times the index
	// ----------------------------------------------------------------
	localparam int ADDR_W = 14;
	localparam logic [11:0] IDX_ALARM_STATUS = 12'h2c1;
	localparam logic [11:0] IDX_LANE_FLAGS = 12'h2c4;
	localparam logic [11:0] IDX_CORE0_TRIM = 12'h330;
	localparam logic [11:0] IDX_CORE1_TRIM = 12'h332;
	localparam logic [11:0] IDX_CORE2A_TRIM = 12'h334;
	localparam logic [11:0] IDX_CAL_CTRL = 12'h3f0;
	localparam logic [11:0] IDX_CAL_STATUS = 12'h3f1;

	// ----------------------------------------------------------------
	// Field positions and widths
	// ----------------------------------------------------------------
	localparam int MAX_LANES = 8;
	localparam int NUM_CORES = 3;
	localparam int TRIM_W = 12;
	localparam int TRIM_REG_W = 16;
	localparam int SUMMARY_BIT = 5;
	localparam int OFFSET_CAL_ENABLE_BIT = 0;
	localparam int BACKGROUND_CAL_ENABLE_BIT = 1;
	localparam int BACKGROUND_OFFSET_TRACKING_ENABLE_BIT = 2;
	localparam int STAT_FOREGROUND_CAL_DONE_BIT = 0;
	localparam int STAT_BUSY_BIT = 1;
	localparam int STAT_VIOL_BIT = 2;

	// ----------------------------------------------------------------
	// Reset values and bus answers
	// ----------------------------------------------------------------
	localparam logic [7:0] LANE_FLAGS_RST = 8'hff;
	localparam logic SUMMARY_RST = 1'h1;
	localparam logic [15:0] TRIM_RST = 16'h0000;
	localparam logic [2:0] CAL_CTRL_RST = 3'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	// ----------------------------------------------------------------
	// Bus carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic awvalid;
		logic [ADDR_W-1:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [ADDR_W-1:0] araddr;
		logic rready;
	} axil_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} axil_rsp_t;

	// ----------------------------------------------------------------
	// Whole state of the bank
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] lane_flags;
		logic summary;
		logic [NUM_CORES-1:0][TRIM_REG_W-1:0] trim_shadow;
		logic [NUM_CORES-1:0][1:0] trim_seen;
		logic [NUM_CORES-1:0][TRIM_W-1:0] trim_apply;
		logic [TRIM_W-1:0] core2_out;
		logic core2_active;
		logic [2:0] cal_ctrl;
		logic violation;
		logic aw_held;
		logic [ADDR_W-1:0] awaddr;
		logic w_held;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} bank_state_t;

endpackage

`default_nettype wire

// file: testbench/tb.sv
// Self-checking bench for the lane alarm and offset trim register bank.
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import trim_regs_pkg::*;
	typedef struct {logic [11:0] wi; logic [31:0] wd; logic [3:0] ws; logic [11:0] ri; logic [31:0] ex;} row_t;
	row_t rows[6] = '{'{IDX_LANE_FLAGS, 32'h0f, 4'h1, IDX_LANE_FLAGS, 32'hf0},
		'{IDX_ALARM_STATUS, 32'h20, 4'h1, IDX_LANE_FLAGS, 32'h00},
		'{IDX_CORE0_TRIM, 32'h0abc, 4'h3, IDX_CORE0_TRIM, 32'h0abc},
		'{IDX_CORE1_TRIM, 32'h0123, 4'h3, IDX_CORE1_TRIM, 32'h0123},
		'{IDX_CORE2A_TRIM, 32'h0fff, 4'h3, IDX_CORE2A_TRIM, 32'h0fff},
		'{IDX_CAL_CTRL, 32'h2, 4'h1, IDX_CAL_CTRL, 32'h2}};
	logic clk = 1'b0, rst = 1'b1, ce = 1'b1, fuse_load = 1'b0, busy = 1'b0, done = 1'b0, c2a = 1'b1;
	axil_req_t req = '0;
	axil_rsp_t rsp;
	logic [7:0] ovf = '0, unf = '0, act = '0;
	logic [NUM_CORES-1:0][TRIM_W-1:0] fuse = '0;
	logic [TRIM_W-1:0] o0, o1, o2;
	logic o2a, cos, cbg, cbgos;
	logic [31:0] rd;
	logic [1:0] rr;
	int n_mismatch = 0, checks = 0;
	lane_fifo_alarm_and_offset_trim_regs #(.LANES(8)) dut_u (.clk(clk), .rst(rst), .ce(ce), .axi_req(req),
		.axi_rsp(rsp), .lane_overflow(ovf), .lane_underflow(unf), .lane_active(act), .fuse_load(fuse_load),
		.fuse_trim(fuse), .offset_cal_busy(busy), .foreground_cal_done(done), .core2_samples_a(c2a),
		.core0_offset(o0), .core1_offset(o1), .core2_input_a_offset(o2), .core2_input_a_offset_active(o2a),
		.offset_cal_enable(cos), .background_cal_enable(cbg), .background_offset_tracking_enable(cbgos));
	initial begin
		forever #20 clk = ~clk;
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [11:0] i, input logic [31:0] d, input logic [3:0] s);
		@(posedge clk);
		req <= {1'b1, i, 2'h0, 1'b1, d, s, 1'b1, 1'b0, 14'h0, 1'b0};
		forever begin
			@(posedge clk);
			if (rsp.awready) req.awvalid <= 1'b0;
			if (rsp.wready) req.wvalid <= 1'b0;
			rr = rsp.bresp;
			if (rsp.bvalid) break;
		end
		req.bready <= 1'b0;
	endtask
	task automatic rdr(input logic [11:0] i);
		@(posedge clk);
		req <= {1'b0, 14'h0, 1'b0, 32'h0, 4'h0, 1'b0, 1'b1, i, 2'h0, 1'b1};
		forever begin
			@(posedge clk);
			if (rsp.arready) req.arvalid <= 1'b0;
			rd = rsp.rdata;
			rr = rsp.rresp;
			if (rsp.rvalid) break;
		end
		req.rready <= 1'b0;
	endtask
	task automatic viol(input logic [2:0] c, input logic b, input logic d, input logic e);
		wr(IDX_CAL_CTRL, {29'h0, c}, 4'h1);
		busy <= b;
		done <= d;
		chk("cal enables", {29'h0, c}, {29'h0, cbgos, cbg, cos});
		rdr(IDX_CORE1_TRIM);
		rdr(IDX_CAL_STATUS);
		chk("violation", {31'h0, e}, {31'h0, rd[STAT_VIOL_BIT]});
		wr(IDX_CAL_STATUS, 32'h4, 4'h1);
	endtask
	task automatic print_verdict;
		$display("checks %0d n_mismatch %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		print_verdict();
	end
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		rdr(IDX_LANE_FLAGS);
		chk("lane flags", 32'hff, rd);
		rdr(IDX_ALARM_STATUS);
		chk("summary", 32'h20, rd & 32'h20);
		foreach (rows[k]) begin
			wr(rows[k].wi, rows[k].wd, rows[k].ws);
			rdr(rows[k].ri);
			chk("row readback", rows[k].ex, rd);
		end
		chk("core0 out", 32'habc, {20'h0, o0});
		chk("core1 out", 32'h123, {20'h0, o1});
		chk("core2 out", 32'hfff, {20'h0, o2});
		chk("core2 active on A", 32'h1, {31'h0, o2a});
		$display("test table done");
		ovf <= 8'h08;
		act <= 8'h40;
		wr(IDX_LANE_FLAGS, 32'h08, 4'h1);
		rdr(IDX_LANE_FLAGS);
		chk("persisting lane", 32'h08, rd);
		rdr(IDX_ALARM_STATUS);
		chk("inactive summary", 32'h0, rd & 32'h20);
		ovf <= 8'h00;
		unf <= 8'h40;
		@(posedge clk);
		unf <= 8'h00;
		rdr(IDX_LANE_FLAGS);
		chk("lane set", 32'h48, rd);
		rdr(IDX_ALARM_STATUS);
		chk("active summary", 32'h20, rd & 32'h20);
		wr(IDX_ALARM_STATUS, 32'h20, 4'h1);
		rdr(IDX_LANE_FLAGS);
		chk("summary clears lanes", 32'h0, rd);
		$display("test lanes done");
		wr(IDX_CORE0_TRIM, 32'h34, 4'h1);
		repeat (2) @(posedge clk);
		chk("half written", 32'habc, {20'h0, o0});
		wr(IDX_CORE0_TRIM, 32'h0200, 4'h2);
		repeat (2) @(posedge clk);
		chk("both bytes", 32'h234, {20'h0, o0});
		c2a <= 1'b0;
		ce <= 1'b0;
		ovf <= 8'h01;
		repeat (3) @(posedge clk);
		ce <= 1'b1;
		ovf <= 8'h00;
		repeat (2) @(posedge clk);
		chk("core2 off input A", 32'h0, {20'h0, o2});
		chk("core2 active off A", 32'h0, {31'h0, o2a});
		rdr(IDX_LANE_FLAGS);
		chk("no fault taken while frozen", 32'h0, rd);
		fuse <= {12'h111, 12'h222, 12'h333};
		fuse_load <= 1'b1;
		@(posedge clk);
		fuse_load <= 1'b0;
		repeat (2) @(posedge clk);
		chk("fuse core1", 32'h222, {20'h0, o1});
		$display("test trims done");
		rdr(12'h100);
		chk("unmapped resp", {30'h0, RESP_DECERR}, {30'h0, rr});
		viol(3'h0, 1'b1, 1'b0, 1'b1);
		viol(3'h1, 1'b0, 1'b0, 1'b1);
		viol(3'h1, 1'b0, 1'b1, 1'b0);
		viol(3'h6, 1'b0, 1'b1, 1'b1);
		viol(3'h3, 1'b0, 1'b1, 1'b0);
		viol(3'h0, 1'b0, 1'b0, 1'b0);
		$display("test calibration done");
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rdr(IDX_LANE_FLAGS);
		chk("flags after reset", 32'hff, rd);
		$display("test reset done");
		print_verdict();
	end
endmodule
`default_nettype wire

// file: testbench/trim_bank_properties.sv
// Concurrent checks on the ports of the lane alarm and offset trim bank.
`default_nettype none
module trim_bank_checker #(
	parameter int LANES = 8
) (
	input wire logic clk, // Clock.
	input wire logic rst, // Reset.
	input wire logic ce, // Clock enable.
	input wire trim_regs_pkg::axil_req_t axi_req, // Bus request.
	input wire trim_regs_pkg::axil_rsp_t axi_rsp, // Bus answer.
	input wire logic fuse_load, // Fuse pulse.
	input wire logic [trim_regs_pkg::NUM_CORES-1:0][trim_regs_pkg::TRIM_W-1:0] fuse_trim, // Fuse trims.
	input wire logic core2_samples_a, // Core 2 on input A.
	input wire logic [trim_regs_pkg::TRIM_W-1:0] core0_offset, // Core 0 trim.
	input wire logic [trim_regs_pkg::TRIM_W-1:0] core1_offset, // Core 1 trim.
	input wire logic [trim_regs_pkg::TRIM_W-1:0] core2_input_a_offset, // Core 2 trim.
	input wire logic core2_input_a_offset_active // Core 2 trim in use.
);
	import trim_regs_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	reset_idle_a: assert property (disable iff (1'b0) rst |=> !axi_rsp.bvalid && !axi_rsp.rvalid)
		else $error("bus answer pending after reset");
	read_answer_a: assert property (axi_req.arvalid && axi_rsp.arready && ce |=> axi_rsp.rvalid)
		else $error("read answer late");
	bresp_hold_a: assert property (axi_rsp.bvalid && !(axi_req.bready && ce) |=>
		axi_rsp.bvalid && $stable(axi_rsp.bresp))
		else $error("write answer dropped");
	rdata_hold_a: assert property (axi_rsp.rvalid && !(axi_req.rready && ce) |=>
		axi_rsp.rvalid && $stable(axi_rsp.rdata))
		else $error("read answer dropped");
	write_busy_a: assert property (axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready)
		else $error("write taken while answer pending");
	core2_zero_a: assert property (ce && !core2_samples_a |=> core2_input_a_offset == 12'h000)
		else $error("core 2 trim applied off input A");
	core2_flag_a: assert property (ce && !rst |=> core2_input_a_offset_active == $past(core2_samples_a))
		else $error("core 2 active flag wrong");
	trim_freeze_a: assert property (!ce |=> $stable(core0_offset) && $stable(core1_offset))
		else $error("trim moved while clock enable low");
	fuse_apply_a: assert property (fuse_load && ce && axi_rsp.awready && axi_rsp.wready && !axi_req.wvalid
		|=> core0_offset == $past(fuse_trim[0]) && core1_offset == $past(fuse_trim[1]))
		else $error("fuse trim not applied");
endmodule
bind lane_fifo_alarm_and_offset_trim_regs trim_bank_checker #(.LANES(LANES)) chk_u (.clk(clk), .rst(rst),
	.ce(ce), .axi_req(axi_req), .axi_rsp(axi_rsp), .fuse_load(fuse_load), .fuse_trim(fuse_trim),
	.core2_samples_a(core2_samples_a), .core0_offset(core0_offset), .core1_offset(core1_offset),
	.core2_input_a_offset(core2_input_a_offset), .core2_input_a_offset_active(core2_input_a_offset_active));
`default_nettype wire
